// file: core/gpd_top.sv
`timescale 1ns/100ps
// Twelve-pin general purpose port with APB access
module gpd_top #(
    parameter int NPINS = gpd_pkg::PIN_COUNT  // Pin count
) (
    input  wire logic             pclk,      // APB clock 10 MHz
    input  wire logic             presetn,   // Async reset, low
    input  wire logic             psel,      // Slave select
    input  wire logic             penable,   // Access phase
    input  wire logic             pwrite,    // Write direction
    input  wire logic [11:0]      paddr,     // Byte address
    input  wire logic [31:0]      pwdata,    // Write data
    input  wire logic [3:0]       pstrb,     // Byte strobes
    output logic                  pready,    // Transfer done
    output logic [31:0]           prdata,    // Read data
    output logic                  pslverr,   // Error response
    input  wire logic [1:0]       ev_in,     // Compare events 9:8
    input  wire logic [NPINS-1:0] pin_i,     // Pin levels
    output logic [NPINS-1:0]      pin_o,     // Pin drive level
    output logic [NPINS-1:0]      pin_oe_n   // Pin enable, low drives
);
    // Registers
    logic [NPINS-1:0] type_q;     // Driver types
    logic [NPINS-1:0] dir_q;      // Direction bits
    logic [NPINS-1:0] data_q;     // Written data
    logic [1:0]       oe_q;       // Event output enables
    logic             pol8_q;     // Pin 8 event polarity
    logic             pol9_q;     // Pin 9 event polarity
    logic             pready_q;   // Answer flag
    logic [31:0]      prdata_q;   // Read data hold
    logic             pslverr_q;  // Error hold
    logic [NPINS-1:0] pin_o_q;    // Registered pin level
    logic [NPINS-1:0] pin_oe_n_q; // Registered enable

    // Decode
    wire logic        setup     = psel & ~penable;
    wire logic        hit_cfg   = paddr == gpd_pkg::OFS_CFG;
    wire logic        hit_dd    = paddr == gpd_pkg::OFS_DATA_DIR;
    wire logic        unmapped  = ~(hit_cfg | hit_dd);
    wire logic        done      = psel & penable & pready_q;
    wire logic        wr_cfg    = done & pwrite & hit_cfg;
    wire logic        wr_dd     = done & pwrite & hit_dd;

    // Merge a byte-strobed write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Current register images
    wire logic [31:0] cfg_img = {16'h0000, oe_q, pol9_q, pol8_q,
                                 type_q};
    wire logic [31:0] dd_raw  = {4'h0, dir_q, 4'h0, data_q};
    wire logic [31:0] cfg_new = merge(cfg_img, pwdata, pstrb);
    wire logic [31:0] dd_new  = merge(dd_raw, pwdata, pstrb);

    // Effective direction per pin
    logic [NPINS-1:0] dir_eff;    // Pin is an output
    logic [NPINS-1:0] is_ev;      // Pin carries events
    always_comb begin
        // (RULE8) Direction bits alone by default
        dir_eff = dir_q;
        is_ev   = '0;
        // (RULE9) Event enables join pins 9-8
        is_ev[8]   = oe_q[0];
        is_ev[9]   = oe_q[1];
        // (RULE10) Enable overrides direction bit
        dir_eff[8] = dir_q[8] | oe_q[0];
        dir_eff[9] = dir_q[9] | oe_q[1];
    end

    // (RULE7) Inputs live, outputs written value
    wire logic [NPINS-1:0] data_rd = (pin_i & ~dir_eff) |
                                     (data_q & dir_eff);
    wire logic [31:0] dd_img = {4'h0, dir_q, 4'h0, data_rd};
    wire logic [31:0] rd_mux = hit_cfg ? cfg_img :
                               hit_dd  ? dd_img  : gpd_pkg::RD_ZERO;

    // Per-pin drivers
    logic [NPINS-1:0] cell_val;   // Combinational pin level
    logic [NPINS-1:0] cell_oe_n;  // Combinational enable
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        gpd_pin_cell u_cell (
            .is_event (is_ev[i]),
            .ev_level ((i == 8) ? ev_in[0] : (i == 9) ? ev_in[1] : 1'b0),
            .ev_pol   ((i == 8) ? pol8_q : pol9_q),
            .dir_out  (dir_eff[i]),
            .push_pull(type_q[i]),
            .data_bit (data_q[i]),
            .pin_val  (cell_val[i]),
            .pin_oe_n (cell_oe_n[i])
        );
    end

    // Configuration register (RULE1 RULE2 RULE11)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_q <= gpd_pkg::RST_TYPE;
            oe_q   <= gpd_pkg::RST_OE;
            pol8_q <= gpd_pkg::RST_POL;
            pol9_q <= gpd_pkg::RST_POL;
        end else if (wr_cfg) begin
            type_q <= cfg_new[gpd_pkg::CFG_TYPE_LSB +: NPINS];
            oe_q   <= cfg_new[gpd_pkg::CFG_OE_LSB +: 2];
            pol8_q <= cfg_new[gpd_pkg::CFG_POL8];
            pol9_q <= cfg_new[gpd_pkg::CFG_POL9];
        end
    end

    // Data and direction register (RULE5 RULE6)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q  <= gpd_pkg::RST_DIR;
            data_q <= gpd_pkg::RST_DATA;
        end else if (wr_dd) begin
            dir_q  <= dd_new[gpd_pkg::DD_DIR_LSB +: NPINS];
            data_q <= dd_new[gpd_pkg::DD_DATA_LSB +: NPINS];
        end
    end

    // APB answer: no wait state, ready in first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= gpd_pkg::RD_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            if (setup) begin
                prdata_q  <= pwrite ? gpd_pkg::RD_ZERO : rd_mux;
                pslverr_q <= unmapped;
            end else begin
                prdata_q  <= gpd_pkg::RD_ZERO;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Pin outputs registered; idle released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_o_q    <= '0;
            pin_oe_n_q <= '1;
        end else begin
            pin_o_q    <= cell_val;
            pin_oe_n_q <= cell_oe_n;
        end
    end

    assign pready   = pready_q;
    assign prdata   = prdata_q;
    assign pslverr  = pslverr_q;
    assign pin_o    = pin_o_q;
    assign pin_oe_n = pin_oe_n_q;
endmodule : gpd_top

// file: core/gpd_pkg.sv
// Overview of operation
// (RULE1) Pin 8 event polarity bit, reset high
// (RULE2) Per-pin driver type: 0 open-drain, 1 push-pull
// (RULE3) Open-drain output drives low on zero only
// (RULE4) Open-drain active-low event: low during event
// (RULE5) Per-pin direction bits, 1 output, reset zero
// (RULE6) Output pins show last written data bit
// (RULE7) Data read: inputs live, outputs written value
// (RULE8) Pins 11-10, 7-0 direction from bits only
// (RULE9) Pins 9-8 direction from bits and event enables
// (RULE10) Event enable forces output, keeps driver type
// (RULE11) Pin 9 event polarity bit, reset high
// (RULE12) Open-drain active-high event: released during event
package gpd_pkg;
    localparam int          PIN_COUNT    = 12;           // Number of pins
    localparam logic [11:0] OFS_CFG      = 12'h1E0;      // Configuration word
    localparam logic [11:0] OFS_DATA_DIR = 12'h1E4;      // Data and direction
    // Configuration field positions
    localparam int          CFG_OE_LSB   = 14;           // Event enables 15:14
    localparam int          CFG_POL9     = 13;           // Pin 9 polarity
    localparam int          CFG_POL8     = 12;           // Pin 8 polarity
    localparam int          CFG_TYPE_LSB = 0;            // Driver type 11:0
    // Data and direction field positions
    localparam int          DD_DIR_LSB   = 16;           // Direction 27:16
    localparam int          DD_DATA_LSB  = 0;            // Data 11:0
    // Reset values
    localparam logic [11:0] RST_TYPE     = 12'h000;      // All open-drain
    localparam logic [11:0] RST_DIR      = 12'h000;      // All inputs
    localparam logic [11:0] RST_DATA     = 12'h000;      // All zero
    localparam logic [1:0]  RST_OE       = 2'h0;         // Events off
    localparam logic        RST_POL      = 1'b1;         // Active high
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000; // Unmapped read
endpackage : gpd_pkg

// file: core/gpd_pin_cell.sv
`timescale 1ns/100ps
// One pin driver: chooses source, level and enable
module gpd_pin_cell (
    input  wire logic is_event,    // Pin carries compare events
    input  wire logic ev_level,    // Event active now
    input  wire logic ev_pol,      // 1 active high, 0 active low
    input  wire logic dir_out,     // Effective direction output
    input  wire logic push_pull,   // Driver type
    input  wire logic data_bit,    // Written data value
    output logic      pin_val,     // Level to drive
    output logic      pin_oe_n     // Low while driving
);
    wire logic ev_pin;             // Event level at pin polarity
    wire logic src;                // Selected output level
    // Event level shaped by polarity (RULE1, RULE11)
    assign ev_pin = ev_pol ? ev_level : ~ev_level;
    // (RULE6) Data or event source
    assign src = is_event ? ev_pin : data_bit;
    // (RULE3) Open-drain drives only zeros; RULE4 RULE12 follow
    assign pin_val  = push_pull ? src : 1'b0;
    // (RULE10) Driver type kept for events
    assign pin_oe_n = ~(dir_out & (push_pull | ~src));
endmodule : gpd_pin_cell

// file: verif/gpd_props.sv
`timescale 1ns/100ps
module gpd_props #(
    parameter int NPINS = 12  // Pin count
) (
    input wire logic             pclk,     // Clock
    input wire logic             presetn,  // Reset, low
    input wire logic             psel,     // Select
    input wire logic             penable,  // Access
    input wire logic             pwrite,   // Write
    input wire logic [11:0]      paddr,    // Address
    input wire logic [31:0]      pwdata,   // Write data
    input wire logic             pready,   // Done
    input wire logic [31:0]      prdata,   // Read data
    input wire logic             pslverr,  // Error
    input wire logic [1:0]       ev_in,    // Events 9:8
    input wire logic [NPINS-1:0] pin_i,    // Pin levels
    input wire logic [NPINS-1:0] pin_o,    // Drive level
    input wire logic [NPINS-1:0] pin_oe_n  // Low drives
);
    logic [15:0] cfg_q;  // Config shadow
    logic [23:0] dd_q;   // Direction and data shadow
    wire         wr   = psel && penable && pready && pwrite;
    wire  [1:0]  evl  = ev_in ^ ~cfg_q[13:12];
    wire  [1:0]  es   = cfg_q[15:14] & evl | ~cfg_q[15:14] & dd_q[9:8];
    wire  [11:0] edir = dd_q[23:12] | {2'h0, cfg_q[15:14], 8'h00};
    wire  [11:0] src  = {dd_q[11:10], es, dd_q[7:0]};
    wire  [11:0] eoe  = ~(edir & (cfg_q[11:0] | ~src));
    wire  [11:0] rdv  = edir & dd_q[11:0] | ~edir & pin_i;
    // Shadow follows accepted writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 16'h3000;
            dd_q  <= 24'h000000;
        end else if (wr && paddr == gpd_pkg::OFS_CFG) begin
            cfg_q <= pwdata[15:0];
        end else if (wr && paddr == gpd_pkg::OFS_DATA_DIR) begin
            dd_q <= {pwdata[27:16], pwdata[11:0]};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd(a); pready && !pwrite && paddr == a; endsequence
    chk_ready_access: assert property (s_setup |=> pready)
        else $error("no ready in access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    chk_err_map: assert property (pready |-> pslverr ==
        (paddr != gpd_pkg::OFS_CFG && paddr != gpd_pkg::OFS_DATA_DIR))
        else $error("wrong error response");
    chk_read_dd: assert property (s_rd(gpd_pkg::OFS_DATA_DIR) |->
        prdata == {4'h0, $past(dd_q[23:12]), 4'h0, $past(rdv)})
        else $error("data read wrong");
    chk_read_cfg: assert property (s_rd(gpd_pkg::OFS_CFG) |->
        prdata == {16'h0, $past(cfg_q)}) else $error("config read wrong");
    chk_oe_plain: assert property ((pin_oe_n & 12'hCFF) ==
        ($past(eoe) & 12'hCFF)) else $error("plain pin enable wrong");
    chk_oe_event: assert property (pin_oe_n[9:8] ==
        $past(eoe[9:8])) else $error("event pin enable wrong");
    chk_lvl_drive: assert property (((pin_o ^ $past(src))
        & ~pin_oe_n) == 12'h000) else $error("driven level wrong");
endmodule : gpd_props
bind gpd_top gpd_props #(.NPINS(NPINS)) gpd_props_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ev_in(ev_in), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n));

// file: verif/gpd_board.sv
`timescale 1ns/100ps
module gpd_board (
    input wire logic [11:0] pin_o,    // Device level
    input wire logic [11:0] pin_oe_n, // Device enable, low drives
    input wire logic [11:0] ext_en,   // Board drives pin
    input wire logic [11:0] ext_val,  // Board level
    output logic     [11:0] pin_lvl   // Wire level
);
    // Device, else board, else pull-up
    assign pin_lvl = ~pin_oe_n & pin_o |
                     pin_oe_n & (ext_en & ext_val | ~ext_en);
endmodule : gpd_board

// file: verif/tb_gpio_pin_drive_and_direction.sv
`timescale 1ns/100ps
module tb_gpio_pin_drive_and_direction;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000, ext_en = 12'hFFF, ext_val = 12'h7E0;
    logic [31:0] pwdata = 32'h0, prdata, rd, sd = 32'h1FEBF7E0;
    logic [11:0] pin_o, pin_oe_n, lvl, edir, dir, dat, ex;
    logic [15:0] cfg;     // Config written
    logic [1:0]  ev_in = 2'h0;
    int          n_errors = 0, n_tests = 0;
    gpd_top gpd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ev_in(ev_in), .pin_i(lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n));
    gpd_board gpd_board_i (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(lvl));
    initial forever #50 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Source per pin: event level or data
    function automatic logic [11:0] src(input logic [15:0] c,
                                        input logic [11:0] d,
                                        input logic [1:0] e);
        return {d[11:10], c[15:14] & (e ^ ~c[13:12]) | ~c[15:14] & d[9:8],
                d[7:0]};
    endfunction : src
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
    endtask : apb
    task automatic test_done();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, gpd_pkg::OFS_CFG, 32'h0, rd);
        chk(rd, 32'h0000_3000);
        apb(1'b0, gpd_pkg::OFS_DATA_DIR, 32'h0, rd);
        chk(rd, 32'h0000_07E0);
        apb(1'b1, 12'h1E8, 32'hFFFF_FFFF, rd);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h1E8, 32'h0, rd);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int i = 0; i < 30; i++) begin
            sd = lfsr(sd);
            cfg = (i == 0) ? 16'hC000 : sd[15:0];
            dir = (i == 0) ? 12'h000 : sd[27:16];
            sd = lfsr(sd);
            dat = sd[11:0];
            apb(1'b1, gpd_pkg::OFS_CFG, {16'h0, cfg}, rd);
            apb(1'b1, gpd_pkg::OFS_DATA_DIR, {4'h0, dir, 4'h0, dat}, rd);
            apb(1'b0, gpd_pkg::OFS_CFG, 32'h0, rd);
            chk(rd, {16'h0, cfg});
            edir = dir | {2'h0, cfg[15:14], 8'h00};
            ex = edir & src(cfg, dat, sd[13:12]) | ~edir & sd[31:20];
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            ev_in <= sd[13:12];
            ext_en <= ~edir;
            ext_val <= sd[31:20];
            repeat (3) @(posedge pclk);
            chk({20'h0, lvl}, {20'h0, ex});
            apb(1'b0, gpd_pkg::OFS_DATA_DIR, 32'h0, rd);
            ex = edir & dat | ~edir & sd[31:20];
            chk(rd, {4'h0, dir, 4'h0, ex});
        end
        test_done();
    end
endmodule : tb_gpio_pin_drive_and_direction
